// File: logic/ckb_key_builder.sv
// Purpose: Build single- and double-width keys for the match stage
// Assumes: Frame fields valid while i_req is high; one key per request
// Notes:   Registers over Avalon-MM; keys registered, one cycle latency
`timescale 1ns/1ps
`default_nettype none
`include "ckb_map.svh"
module ckb_key_builder
#(
  parameter int GIDX_W = `CKB_GIDX_W,
  parameter int PORT_W = `CKB_PORT_W
)
(
  input  wire logic                     i_clock,
  input  wire logic                     i_srst,
  // Avalon-MM slave
  input  wire logic [`CKB_ADDR_W-1:0]   i_address,
  input  wire logic                     i_read,
  input  wire logic                     i_write,
  input  wire logic [31:0]              i_writedata,
  input  wire logic [3:0]               i_byteenable,
  output logic      [31:0]              o_readdata,
  output logic                          o_waitrequest,
  output logic      [1:0]               o_response,
  // Key request
  input  wire logic                     i_req,
  input  wire logic [1:0]               i_kind,
  input  wire logic                     i_first,
  input  wire logic                     i_prev_valid,
  input  wire logic [`CKB_NIC_W-1:0]    i_next_index_control,
  input  wire logic [GIDX_W-1:0]        i_next_index_value,
  input  wire logic [GIDX_W-1:0]        i_prev_bind_index,
  input  wire logic [PORT_W-1:0]        i_masq_port,
  input  wire logic [`CKB_LABEL_W-1:0]  i_top_label_value,
  input  wire logic                     i_top_bottom_of_stack_bit,
  input  wire logic [`CKB_TTL_W-1:0]    i_ttl0,
  input  wire logic [`CKB_LABEL_W-1:0]  i_lbl1,
  input  wire logic                     i_sbit1,
  input  wire logic [`CKB_TTL_W-1:0]    i_ttl1,
  input  wire logic                     i_tag0_present,
  input  wire logic [15:0]              i_tag0_tpid,
  input  wire logic [`CKB_PCP_W-1:0]    i_tag0_pcp,
  input  wire logic                     i_tag0_dei,
  input  wire logic [`CKB_VID_W-1:0]    i_tag0_vid,
  input  wire logic                     i_tag1_present,
  input  wire logic [15:0]              i_tag1_tpid,
  input  wire logic [`CKB_PCP_W-1:0]    i_cl_pcp,
  input  wire logic                     i_cl_dei,
  input  wire logic [`CKB_VID_W-1:0]    i_cl_vid,
  // Key outputs
  output logic                          o_key_valid,
  output logic                          o_key_wide,
  output logic      [`CKB_KEY2_W-1:0]   o_key
);
  localparam int K1W = `CKB_KEY1_W;

  logic [31:0]          ctrl_ff;
  logic [31:0]          port_ff;
  logic [15:0]          count_ff;
  logic [1:0]           last_kind_ff;
  ckb_pkg::ckb_bus_st_t bus_st_ff;
  ckb_pkg::ckb_bus_st_t nxt_bus_st;
  logic                 bus_ack;
  logic [2:0]           tpc0;
  logic [2:0]           tpc1;
  logic [GIDX_W-1:0]    gidx;
  logic [GIDX_W-1:0]    gidx_def;
  logic [PORT_W-1:0]    lport;
  logic                 use_cl;
  logic [2:0]           outer_priority;
  logic                 outer_drop_eligible;
  logic [11:0]          outer_vlan_id;
  logic                 exp0;
  logic                 exp1;
  logic [`CKB_KEY2_W-1:0] nxt_key;
  logic                 nxt_wide;
  logic                 req_ok;
  logic [15:0]          cust1;
  logic [15:0]          cust2;
  logic [15:0]          cust3;

  assign lport = port_ff[`CKB_PORT_LPORT_LSB +: PORT_W];

  // Custom identifiers; a zero custom-3 byte disables that match
  always_comb
  begin
    cust1 = ctrl_ff[`CKB_CTRL_CUST1_LSB +: 16];
    cust2 = port_ff[`CKB_PORT_CUST2_LSB +: 16];
    if (port_ff[`CKB_PORT_CUST3_LSB +: 8] == 8'h00)
      cust3 = `CKB_TPID_C;
    else
      cust3 = {port_ff[`CKB_PORT_CUST3_LSB +: 8], 8'h00};
  end

  ckb_tag_code u_outer_code
  (
    .i_present (i_tag0_present),
    .i_tpid    (i_tag0_tpid),
    .i_custom1 (cust1),
    .i_custom2 (cust2),
    .i_custom3 (cust3),
    .o_code    (tpc0)
  );

  ckb_tag_code u_inner_code
  (
    .i_present (i_tag1_present),
    .i_tpid    (i_tag1_tpid),
    .i_custom1 (cust1),
    .i_custom2 (cust2),
    .i_custom3 (cust3),
    .o_code    (tpc1)
  );

  // Default bind index
  always_comb
  begin
    case (ctrl_ff[`CKB_CTRL_DEFSEL_LSB +: 2])
      `CKB_DEF_LPORT: gidx_def = GIDX_W'(lport);
      `CKB_DEF_MPORT: gidx_def = GIDX_W'(i_masq_port);
      default:        gidx_def = '0;
    endcase
  end

  // Bind index from previous action
  always_comb
  begin
    if (!i_prev_valid)
      gidx = gidx_def;
    else
    begin
      case (i_next_index_control)
        `CKB_NIC_NONE:    gidx = i_prev_bind_index;
        `CKB_NIC_REPLACE: gidx = i_next_index_value;
        `CKB_NIC_ADD:     gidx = GIDX_W'(i_prev_bind_index
                                 + i_next_index_value);
        default:          gidx = i_prev_bind_index;
      endcase
    end
  end

  assign use_cl = i_first ? ctrl_ff[`CKB_CTRL_USECL0_BIT]
                          : ctrl_ff[`CKB_CTRL_USECL1_BIT];

  // Outer tag fields: frame or classified, per lookup
  always_comb
  begin
    if (use_cl)
    begin
      outer_priority = i_cl_pcp;
      outer_drop_eligible = i_cl_dei;
      outer_vlan_id = i_cl_vid;
    end
    else
    begin
      outer_priority = i_tag0_pcp;
      outer_drop_eligible = i_tag0_dei;
      outer_vlan_id = i_tag0_vid;
    end
    if (!i_tag0_present)
      outer_vlan_id = '0;
  end

  assign exp0 = i_ttl0 <= `CKB_TTL_EXPIRE_MAX;
  assign exp1 = i_ttl1 <= `CKB_TTL_EXPIRE_MAX;
  assign req_ok = i_req;

  // Key assembly, first listed field at the top, type at bit 0
  always_comb
  begin
    nxt_key  = '0;
    nxt_wide = 1'b1;
    case (i_kind)
      `CKB_TYPE_TRIPLE_VLAN_KEY:
        nxt_key = `CKB_KEY2_W'({i_first, lport,
                  tpc0, outer_priority, outer_drop_eligible, outer_vlan_id, tpc1,
                  `CKB_TYPE_TRIPLE_VLAN_KEY});
      `CKB_TYPE_DBL_LBL:
        nxt_key = `CKB_KEY2_W'({i_first, gidx, i_top_label_value, i_top_bottom_of_stack_bit, exp0,
                  i_lbl1, i_sbit1, exp1,
                  `CKB_TYPE_DBL_LBL});
      `CKB_TYPE_TRI_IDX:
        nxt_key = `CKB_KEY2_W'({i_first, gidx, tpc0,
                  outer_vlan_id, tpc1,
                  `CKB_TYPE_TRI_IDX});
      default:
      begin
        // Single-width key: no type field; reserved code never emitted
        nxt_wide = 1'b0;
        nxt_key  = `CKB_KEY2_W'({i_first, gidx,
                   i_top_label_value, i_top_bottom_of_stack_bit,
                   exp0});
      end
    endcase
  end

  // Key output stage
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_key_valid <= 1'b0;
      o_key_wide  <= 1'b0;
      o_key       <= '0;
    end
    else
    begin
      o_key_valid <= req_ok;
      if (req_ok)
      begin
        o_key_wide <= nxt_wide;
        o_key      <= nxt_key;
      end
    end
  end

  // Statistics
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      count_ff     <= 16'h0000;
      last_kind_ff <= 2'h0;
    end
    else if (req_ok)
    begin
      count_ff     <= count_ff + 16'h0001;
      last_kind_ff <= i_kind;
    end
  end

  // Bus: one wait cycle, answer on second cycle
  always_comb
  begin
    case (bus_st_ff)
      ckb_pkg::CKB_ST_IDLE:
        nxt_bus_st = (i_read || i_write) ? ckb_pkg::CKB_ST_BUSY
                                         : ckb_pkg::CKB_ST_IDLE;
      ckb_pkg::CKB_ST_BUSY:
        nxt_bus_st = ckb_pkg::CKB_ST_IDLE;
      default:
        nxt_bus_st = ckb_pkg::CKB_ST_IDLE;
    endcase
  end

  // Waitrequest idles high, drops only in the answer cycle
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      bus_st_ff     <= ckb_pkg::CKB_ST_IDLE;
      o_waitrequest <= 1'b1;
    end
    else
    begin
      bus_st_ff     <= nxt_bus_st;
      o_waitrequest <= nxt_bus_st != ckb_pkg::CKB_ST_BUSY;
    end
  end

  assign bus_ack = bus_st_ff == ckb_pkg::CKB_ST_BUSY;

  // Configuration writes
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      ctrl_ff <= `CKB_CTRL_RST;
      port_ff <= `CKB_PORT_RST;
    end
    else if (i_write && bus_ack)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (i_byteenable[b] && i_address == `CKB_REG_CTRL)
          ctrl_ff[b*8 +: 8] <= i_writedata[b*8 +: 8];
        if (i_byteenable[b] && i_address == `CKB_REG_PORT)
          port_ff[b*8 +: 8] <= i_writedata[b*8 +: 8];
      end
    end
  end

  // Read data
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_readdata <= 32'h0000_0000;
      o_response <= `CKB_RSP_OK;
    end
    else if (i_read && !bus_ack)
    begin
      o_response <= `CKB_RSP_OK;
      case (i_address)
        `CKB_REG_CTRL:   o_readdata <= ctrl_ff;
        `CKB_REG_PORT:   o_readdata <= port_ff;
        `CKB_REG_STATUS: o_readdata <= {29'h0, o_key_wide, last_kind_ff};
        `CKB_REG_COUNT:  o_readdata <= {16'h0000, count_ff};
        default:
        begin
          o_readdata <= 32'h0000_0000;
          o_response <= `CKB_RSP_SLVERR;
        end
      endcase
    end
  end
endmodule // ckb_key_builder
`default_nettype wire

// File: logic/ckb_map.svh
// Purpose: Offsets, field widths, codes and reset values of the key builder
// Assumes: Avalon-MM word addressing, byte offsets multiple of four
// Notes:   Definitions only
`ifndef CKB_MAP_SVH
`define CKB_MAP_SVH

`define CKB_ADDR_W          4
`define CKB_REG_CTRL        4'h0
`define CKB_REG_PORT        4'h1
`define CKB_REG_STATUS      4'h2
`define CKB_REG_COUNT       4'h3

`define CKB_RD_ERR_DATA     32'hdeadbeef

`define CKB_GIDX_W          12
`define CKB_PORT_W          6
`define CKB_LABEL_W         20
`define CKB_VID_W           12
`define CKB_PCP_W           3
`define CKB_TPC_W           3
`define CKB_TYPE_W          2
`define CKB_TTL_W           8
`define CKB_NIC_W           3

`define CKB_TTL_EXPIRE_MAX  8'h01

`define CKB_TYPE_TRIPLE_VLAN_KEY    2'h0
`define CKB_TYPE_DBL_LBL    2'h1
`define CKB_TYPE_RESERVED   2'h2
`define CKB_TYPE_TRI_IDX    2'h3

`define CKB_TPC_UNTAGGED    3'h0
`define CKB_TPC_C_TAG       3'h1
`define CKB_TPC_S_TAG       3'h4
`define CKB_TPC_CUSTOM1     3'h5
`define CKB_TPC_CUSTOM2     3'h6
`define CKB_TPC_CUSTOM3     3'h7

`define CKB_TPID_C          16'h8100
`define CKB_TPID_S          16'h88a8

`define CKB_DEF_ZERO        2'h0
`define CKB_DEF_LPORT       2'h1
`define CKB_DEF_MPORT       2'h2

`define CKB_NIC_NONE        3'h0
`define CKB_NIC_REPLACE     3'h1
`define CKB_NIC_ADD         3'h2

// Control register fields
`define CKB_CTRL_DEFSEL_LSB 0
`define CKB_CTRL_USECL0_BIT 2
`define CKB_CTRL_USECL1_BIT 3
`define CKB_CTRL_CUST1_LSB  16

// Port register fields
`define CKB_PORT_LPORT_LSB  0
`define CKB_PORT_CUST3_LSB  8
`define CKB_PORT_CUST2_LSB  16

// Bus response codes
`define CKB_RSP_OK          2'h0
`define CKB_RSP_SLVERR      2'h2

`define CKB_CTRL_RST        32'h0000_0000
`define CKB_PORT_RST        32'h0000_0000

`define CKB_KEY1_W          (`CKB_LABEL_W + 1 + 1 + `CKB_GIDX_W + 1)
`define CKB_KEY2_W          64

`endif

// File: logic/ckb_pkg.sv
// Purpose: Types for the key builder
// Assumes: Constants live in ckb_map.svh
// Notes:   Nothing here is imported
`include "ckb_map.svh"
package ckb_pkg;
  typedef enum logic [1:0] {
    CKB_KIND_TRIPLE_VLAN_KEY = `CKB_TYPE_TRIPLE_VLAN_KEY,
    CKB_KIND_DBL_LBL = `CKB_TYPE_DBL_LBL,
    CKB_KIND_TRI_IDX = `CKB_TYPE_TRI_IDX,
    CKB_KIND_SINGLE  = `CKB_TYPE_RESERVED
  } ckb_kind_t;

  typedef enum logic [1:0] {
    CKB_ST_IDLE = 2'h0,
    CKB_ST_BUSY = 2'h1
  } ckb_bus_st_t;
endpackage

// File: logic/ckb_tag_code.sv
// Purpose: Map a tag's protocol identifier to the three-bit tag code
// Assumes: Custom identifiers come from configuration
// Notes:   Used once for the outer and once for the inner tag
`timescale 1ns/1ps
`default_nettype none
`include "ckb_map.svh"
module ckb_tag_code
(
  input  wire logic        i_present,
  input  wire logic [15:0] i_tpid,
  input  wire logic [15:0] i_custom1,
  input  wire logic [15:0] i_custom2,
  input  wire logic [15:0] i_custom3,
  output logic       [2:0] o_code
);
  always_comb
  begin
    if (!i_present)
      o_code = `CKB_TPC_UNTAGGED;
    else if (i_tpid == `CKB_TPID_C)
      o_code = `CKB_TPC_C_TAG;
    else if (i_tpid == `CKB_TPID_S)
      o_code = `CKB_TPC_S_TAG;
    else if (i_tpid == i_custom1)
      o_code = `CKB_TPC_CUSTOM1;
    else if (i_tpid == i_custom2)
      o_code = `CKB_TPC_CUSTOM2;
    else if (i_tpid == i_custom3)
      o_code = `CKB_TPC_CUSTOM3;
    else
      o_code = `CKB_TPC_UNTAGGED;
  end
endmodule // ckb_tag_code
`default_nettype wire

// File: bench/ckb_assertions.sv
// Purpose: Port assertions for the key builder
// Assumes: Master holds each bus request until waitrequest low
// Notes:   Bound to ckb_key_builder below
`timescale 1ns/1ps
`default_nettype none
module ckb_assertions
(
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic        o_waitrequest,
  input wire logic        i_req,
  input wire logic [1:0]  i_kind,
  input wire logic        i_first,
  input wire logic        i_tag0_present,
  input wire logic [19:0] i_top_label_value,
  input wire logic        i_top_bottom_of_stack_bit,
  input wire logic [7:0]  i_ttl0,
  input wire logic        o_key_valid,
  input wire logic        o_key_wide,
  input wire logic [63:0] o_key
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  wire sgl = i_req && i_kind == 2'h2;

  wait_one_a: assert property ((i_read || i_write) && o_waitrequest |=>
    !o_waitrequest) else $error("bus waited more than one cycle");
  key_next_a: assert property (i_req |=> o_key_valid)
    else $error("key valid missing");
  key_pulse_a: assert property (!i_req |=> !o_key_valid)
    else $error("key valid without request");
  no_type_a: assert property (sgl |=>
    !o_key_wide && o_key[63:35] == 29'h0) else $error("single key wide");
  first_flag_a: assert property (sgl |=>
    o_key[34] == $past(i_first)) else $error("first flag wrong");
  top_label_a: assert property (sgl |=>
    o_key[21:1] == $past({i_top_label_value, i_top_bottom_of_stack_bit})) else $error("top label wrong");
  expiry_flag_a: assert property (sgl |=>
    o_key[0] == ($past(i_ttl0) <= 8'h01)) else $error("expiry wrong");
  wide_type_a: assert property (i_req && i_kind != 2'h2 |=>
    o_key_wide && o_key[1:0] == $past(i_kind)) else $error("type wrong");
  no_reserved_a: assert property (o_key_valid && o_key_wide |->
    o_key[1:0] != 2'h2) else $error("reserved type generated");
  untag_vid_a: assert property (i_req && i_kind == 2'h0 &&
    !i_tag0_present |=> o_key[23:21] == 3'h0 && o_key[16:5] == 12'h0)
    else $error("untagged outer fields not zero");

  cover property (sgl ##1 o_key_valid);
  cover property (i_req && i_kind == 2'h0 && !i_tag0_present);
  cover property (i_read && !o_waitrequest);
endmodule // ckb_assertions

bind ckb_key_builder ckb_assertions ckb_assertions_i (.i_clock, .i_srst,
  .i_read, .i_write, .o_waitrequest, .i_req, .i_kind, .i_first,
  .i_tag0_present, .i_top_label_value, .i_top_bottom_of_stack_bit, .i_ttl0, .o_key_valid, .o_key_wide,
  .o_key);
`default_nettype wire

// File: bench/ckb_match_mem.sv
// Purpose: Match memory stand-in watching the generated keys
// Assumes: Key valid is a one-cycle pulse
// Notes:   Holds no entries; flags any wide key that carries the reserved type
`timescale 1ns/1ps
`default_nettype none
module ckb_match_mem
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_valid,
  input  wire logic        i_wide,
  input  wire logic [63:0] i_key,
  output logic             o_rsv_seen
);
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_rsv_seen <= 1'b0;
    else if (i_valid && i_wide && i_key[1:0] == 2'h2)
      o_rsv_seen <= 1'b1;
  end
endmodule // ckb_match_mem
`default_nettype wire

// File: bench/ckb_key_builder_tb_top.sv
// Purpose: Self-checking bench for the key builder
// Assumes: One wait state per bus access, key one cycle after request
// Notes:   Port 2a, custom tags 8847, 9100 and aa00
`timescale 1ns/1ps
`default_nettype none
`include "ckb_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module ckb_key_builder_tb_top;
  logic        i_clock = 1'b0, i_srst, i_read, i_write, i_req, i_first;
  logic        i_prev_valid, i_top_bottom_of_stack_bit, i_sbit1, i_tag0_present;
  logic        i_tag1_present, i_tag0_dei, i_cl_dei;
  logic [3:0]  i_address, i_byteenable;
  logic [31:0] i_writedata, rd;
  logic [1:0]  i_kind, rsp;
  logic [2:0]  i_next_index_control, i_tag0_pcp, i_cl_pcp;
  logic [11:0] i_next_index_value, i_prev_bind_index, i_tag0_vid, i_cl_vid, g;
  logic [5:0]  i_masq_port;
  logic [19:0] i_top_label_value, i_lbl1;
  logic [7:0]  i_ttl0, i_ttl1;
  logic [15:0] i_tag0_tpid, i_tag1_tpid;
  logic [15:0] tp [5] = '{16'h8100, 16'h88a8, 16'h8847, 16'h9100, 16'haa00};
  logic [2:0]  tc [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  wire  [31:0] o_readdata;
  wire  [1:0]  o_response;
  wire  [63:0] o_key;
  wire         o_waitrequest, o_key_valid, o_key_wide, rsv_seen;
  int          n_fail = 0;
  int          check_count = 0;

  ckb_key_builder ckb_key_builder_i (.i_clock, .i_srst, .i_address, .i_read,
    .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
    .o_response, .i_req, .i_kind, .i_first, .i_prev_valid,
    .i_next_index_control, .i_next_index_value, .i_prev_bind_index,
    .i_masq_port, .i_top_label_value, .i_top_bottom_of_stack_bit, .i_ttl0, .i_lbl1, .i_sbit1, .i_ttl1,
    .i_tag0_present, .i_tag0_tpid, .i_tag0_pcp, .i_tag0_dei, .i_tag0_vid,
    .i_tag1_present, .i_tag1_tpid, .i_cl_pcp, .i_cl_dei, .i_cl_vid,
    .o_key_valid, .o_key_wide, .o_key);
  ckb_match_mem ckb_match_mem_i (.i_clock, .i_srst, .i_valid(o_key_valid),
    .i_wide(o_key_wide), .i_key(o_key), .o_rsv_seen(rsv_seen));

  always #12.5 i_clock = ~i_clock;

  task automatic finish_test();
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= d;
    i_read <= !wr;
    i_write <= wr;
    do
    begin
      @(posedge i_clock);
    end
    while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    rsp = o_response;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic key(input logic [1:0] k, input logic [63:0] e,
                     input logic [63:0] m = '1);
    @(posedge i_clock);
    i_req <= 1'b1;
    i_kind <= k;
    @(posedge i_clock);
    i_req <= 1'b0;
    @(posedge i_clock);
    `CHK(o_key_valid, 1'b1)
    `CHK(o_key & m, e)
  endtask

  initial
  begin
    #100us;
    n_fail++;
    finish_test();
  end

  initial
  begin
    {i_read, i_write, i_req, i_first, i_prev_valid, i_top_bottom_of_stack_bit} = '0;
    {i_sbit1, i_tag0_present, i_tag1_present, i_tag0_dei, i_cl_dei} = '0;
    {i_address, i_writedata, i_kind, i_next_index_control, i_cl_pcp} = '0;
    {i_next_index_value, i_prev_bind_index, i_tag0_vid, i_cl_vid} = '0;
    {i_masq_port, i_top_label_value, i_lbl1, i_ttl0, i_ttl1, i_tag0_pcp} = '0;
    {i_tag0_tpid, i_tag1_tpid} = '0;
    i_byteenable = 4'hf;
    i_srst = 1'b1;
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    bus(1'b0, `CKB_REG_CTRL, 32'h0);
    `CHK(rd, `CKB_CTRL_RST)
    bus(1'b1, `CKB_REG_PORT, 32'h9100_aa2a);
    bus(1'b1, `CKB_REG_CTRL, 32'h8847_0000);
    bus(1'b0, `CKB_REG_PORT, 32'h0);
    `CHK(rd, 32'h9100_aa2a)
    bus(1'b0, 4'h9, 32'h0);
    `CHK({rsp, rd}, {2'h2, 32'h0})
    i_top_label_value <= 20'habcde;
    i_top_bottom_of_stack_bit <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      i_first <= i[0];
      i_ttl0 <= 8'(i);
      key(2'h2, {29'h0, i[0], 12'h0, 20'habcde, 1'b1, i < 2});
    end
    i_masq_port <= 6'h15;
    i_lbl1 <= 20'h12345;
    i_ttl1 <= 8'h40;
    for (int s = 0; s < 3; s++)
    begin
      bus(1'b1, `CKB_REG_CTRL, 32'h8847_0000 | s);
      g = (s == 0) ? 12'h0 : (s == 1) ? 12'h02a : 12'h015;
      key(2'h1,
          {5'h0, 1'b1, g, 20'habcde, 2'b10, 20'h12345, 2'b00, 2'h1});
    end
    i_prev_valid <= 1'b1;
    i_prev_bind_index <= 12'h7f0;
    i_next_index_value <= 12'h025;
    i_tag0_present <= 1'b1;
    i_tag0_vid <= 12'h123;
    i_tag0_tpid <= `CKB_TPID_C;
    i_first <= 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      i_next_index_control <= 3'(c);
      g = (c == 0) ? 12'h7f0 : (c == 1) ? 12'h025 : 12'h815;
      key(2'h3, {31'h0, 1'b0, g, 3'h1, 12'h123, 3'h0, 2'h3});
    end
    i_tag0_pcp <= 3'h5;
    i_tag0_dei <= 1'b1;
    i_tag1_present <= 1'b1;
    for (int t = 0; t < 5; t++)
    begin
      i_tag0_tpid <= tp[t];
      i_tag1_tpid <= tp[4 - t];
      key(2'h0,
          {33'h0, 1'b0, 6'h2a, tc[t], 3'h5, 1'b1, 12'h123, tc[4 - t], 2'h0});
    end
    bus(1'b1, `CKB_REG_CTRL, 32'h8847_0004);
    i_cl_pcp <= 3'h2;
    i_cl_vid <= 12'habc;
    i_tag0_tpid <= `CKB_TPID_C;
    for (int f = 0; f < 2; f++)
    begin
      i_first <= f[0];
      key(2'h0,
          f ? {33'h0, 1'b1, 6'h2a, 3'h1, 3'h2, 1'b0, 12'habc, 3'h1, 2'h0}
            : {33'h0, 1'b0, 6'h2a, 3'h1, 3'h5, 1'b1, 12'h123, 3'h1, 2'h0});
    end
    i_tag0_present <= 1'b0;
    i_tag1_present <= 1'b0;
    key(2'h0, 64'h0, 64'h00e1_ffff);
    `CHK(rsv_seen, 1'b0)
    bus(1'b0, `CKB_REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h4)
    bus(1'b0, `CKB_REG_COUNT, 32'h0);
    `CHK(rd[15:0], 16'h12)
    i_byteenable <= 4'h2;
    bus(1'b1, `CKB_REG_PORT, 32'h0000_5500);
    i_byteenable <= 4'hf;
    bus(1'b0, `CKB_REG_PORT, 32'h0);
    `CHK(rd, 32'h9100_552a)
    finish_test();
  end
endmodule // ckb_key_builder_tb_top
`default_nettype wire
